//--- isw_params.svh
// Constants of the auxiliary register bank: offsets, bit positions, resets.
// Included by the package and the bank; definitions only.
`ifndef ISW_PARAMS_SVH
`define ISW_PARAMS_SVH

// ==========================================================
// Register offsets (5-bit register space)
`define ISW_OFF_CFG        5'h0E
`define ISW_OFF_TRIM       5'h12
`define ISW_OFF_PROTECT    5'h17
`define ISW_OFF_SCR3       5'h10
`define ISW_OFF_SCR2       5'h12
`define ISW_OFF_SCR1       5'h14
`define ISW_OFF_SCR0       5'h16

// ==========================================================
// Configuration register fields
`define ISW_CFG_REWRITE    7
`define ISW_CFG_PAGE       6
`define ISW_CFG_FORCE_OSC  5
`define ISW_CFG_CLK_SRC    4
`define ISW_CFG_CLK_EN     3
`define ISW_CFG_WDOG_SEL   2
`define ISW_CFG_INT_CLR    1
`define ISW_CFG_INT_EN     0
`define ISW_CFG_RESET      8'h88

// ==========================================================
// Protect-and-postscale register fields
`define ISW_WP_LSB         4
`define ISW_WP_BROWNOUT    0
`define ISW_WP_APP         1
`define ISW_WP_CAL         2
`define ISW_WP_ID          3

`endif

//--- isw_pkg.sv
// Types shared by the auxiliary register bank.
// Assumes isw_params.svh sits in the include path.
`include "isw_params.svh"

package isw_pkg;

   // ==========================================================
   // Write-protect groups, index into the four flags
   typedef enum logic [1:0] {
      ISW_GRP_BROWNOUT = 2'b00,
      ISW_GRP_APP = 2'b01,
      ISW_GRP_CAL = 2'b10,
      ISW_GRP_ID = 2'b11
   } isw_grp_e;

   // Kind of reset applied in a cycle
   typedef enum logic [1:0] {
      ISW_RST_NONE = 2'b00,
      ISW_RST_POWER = 2'b01,
      ISW_RST_WDOG = 2'b10,
      ISW_RST_BROWN = 2'b11
   } isw_rst_e;

   typedef logic [7:0] isw_byte_t;

endpackage

//--- isw_aux_regs.sv
// Auxiliary register bank: configuration, paged scratchpad/ID bytes,
// group write-protect flags and the crystal load-trim rewrite-once lock.
// Assumes a decoded register port from the serial link logic on the same
// clock, reset events as one-cycle pulses and static factory OTP values.
//
// How it works
// - Four scratch bytes, page 1, even addresses
// - Scratch bytes reload from OTP after reset
// - OTP default zero, custom parts differ
// - Bytes form 32-bit ID, 0x10 most significant
// - Page bit chooses bank at 0x10-0x17
// - Config bit 4 selects clock output source
// - Config bit 2 selects watchdog clock source
// - Config bit 1 write-one clears interrupt flag
// - Bit 0 interrupt enable; config resets 0x88, bit 7 only on power-on
// - Four protect flags in bits 7:4
// - OTP-set protect flag blocks writes forever
// - Clear flag allows writes to its group
// - Software-set flag sticks and blocks writes
// - Power-on or watchdog reset clears software-set flags
// - Brownout leaves protect flags unchanged
// - Load-trim lock independent of protect flags
// - Trim nibble write only right after unlock
`timescale 1ns/1ps
`include "isw_params.svh"

module isw_aux_regs #(
   parameter int ADDR_W = 5
) (
   // Clock, reset and enable
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Reset events from the supervisor, one-cycle pulses
   input wire logic por_evt,
   input wire logic wdog_evt,
   input wire logic bo_evt,
   // Factory OTP contents, static
   input wire logic [31:0] otp_id,
   input wire logic [3:0] otp_wp,
   input wire logic [3:0] otp_ps_low,
   input wire logic [7:0] otp_trim,
   // Register port from the serial link
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Configuration outputs
   output logic page_sel,
   output logic force_osc_on,
   output logic clock_output_src_32k,
   output logic clock_output_en,
   output logic wdog_clk_from_clock_output,
   output logic int_enable,
   output logic int_flag_clr,
   // Protection state
   output logic [3:0] wp_flags,
   output logic [3:0] grp_write_ok,
   output logic rewrite_armed,
   // Stored values
   output logic [31:0] scratch_id,
   output logic [3:0] postscale_low,
   output logic [7:0] load_trim
);

   // ==========================================================
   // State
   isw_pkg::isw_byte_t cfg_r, cfg_nxt;
   isw_pkg::isw_byte_t scr_r [4];
   isw_pkg::isw_byte_t scr_nxt [4];
   logic [3:0] wp_sticky_r, wp_sticky_nxt;
   logic [3:0] wp_otp_r, wp_otp_nxt;
   logic [3:0] ps_low_r, ps_low_nxt;
   isw_pkg::isw_byte_t trim_r, trim_nxt;
   logic armed_r, armed_nxt;
   logic init_r, init_nxt;
   logic int_clr_r, int_clr_nxt;
   isw_pkg::isw_byte_t rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;

   logic [3:0] wp_eff;
   logic power_rst;
   logic warm_rst;
   logic any_rst;
   isw_pkg::isw_rst_e rst_kind;

   // ==========================================================
   // Protection and reset classification
   // Factory-set flags can never be cleared by any reset
   assign wp_eff = wp_otp_r | wp_sticky_r;

   always_comb
   begin
      if (init_r || por_evt)
         rst_kind = isw_pkg::ISW_RST_POWER;
      else if (wdog_evt)
         rst_kind = isw_pkg::ISW_RST_WDOG;
      else if (bo_evt)
         rst_kind = isw_pkg::ISW_RST_BROWN;
      else
         rst_kind = isw_pkg::ISW_RST_NONE;
   end

   assign power_rst = (rst_kind == isw_pkg::ISW_RST_POWER);
   assign warm_rst = power_rst || (rst_kind == isw_pkg::ISW_RST_WDOG);
   assign any_rst = (rst_kind != isw_pkg::ISW_RST_NONE);

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      cfg_nxt = cfg_r;
      for (int i = 0; i < 4; i++)
      begin
         scr_nxt[i] = scr_r[i];
      end
      ps_low_nxt = ps_low_r;
      trim_nxt = trim_r;
      armed_nxt = armed_r;
      init_nxt = init_r;
      int_clr_nxt = int_clr_r;

      if (ce)
      begin
         int_clr_nxt = 1'b0;
         init_nxt = 1'b0;

         if (any_rst)
         begin
            // Reset events win over a register write in the same cycle
            cfg_nxt[6:0] = 7'(`ISW_CFG_RESET & 8'h7F);
            cfg_nxt[`ISW_CFG_INT_CLR] = 1'b0;
            // Rewrite-once enable returns only on power-on
            if (power_rst)
            begin
               cfg_nxt[`ISW_CFG_REWRITE] = 1'(`ISW_CFG_RESET >> 7);
            end
            scr_nxt[3] = otp_id[31:24];
            scr_nxt[2] = otp_id[23:16];
            scr_nxt[1] = otp_id[15:8];
            scr_nxt[0] = otp_id[7:0];
            ps_low_nxt = otp_ps_low;
            trim_nxt = otp_trim;
            armed_nxt = 1'b0;
         end
         else if (reg_wr)
         begin
            // Any write other than the unlock ends the unlock window
            armed_nxt = 1'b0;
            if (reg_addr == `ISW_OFF_CFG)
            begin
               cfg_nxt = reg_wdata;
               cfg_nxt[`ISW_CFG_INT_CLR] = 1'b0;
               int_clr_nxt = reg_wdata[`ISW_CFG_INT_CLR];
               armed_nxt = ~reg_wdata[`ISW_CFG_REWRITE];
            end
            else if (cfg_r[`ISW_CFG_PAGE])
            begin
               // Page 1: scratch bytes at even addresses only
               if (reg_addr[ADDR_W-1:3] == `ISW_OFF_SCR3 >> 3 &&
                   !reg_addr[0])
               begin
                  if (!wp_eff[`ISW_WP_ID])
                  begin
                     scr_nxt[3 - reg_addr[2:1]] = reg_wdata;
                  end
               end
            end
            else if (reg_addr == `ISW_OFF_PROTECT)
            begin
               if (!wp_eff[`ISW_WP_APP])
               begin
                  ps_low_nxt = reg_wdata[3:0];
               end
            end
            else if (reg_addr == `ISW_OFF_TRIM)
            begin
               // Load-cap nibble ignores the group flags
               if (armed_r)
               begin
                  trim_nxt[7:4] = reg_wdata[7:4];
               end
               if (!wp_eff[`ISW_WP_CAL])
               begin
                  trim_nxt[3:0] = reg_wdata[3:0];
               end
            end
         end
      end
   end

   // ==========================================================
   // Read path
   // Reads return the value from before a write on the same edge
   always_comb
   begin
      rdata_nxt = rdata_r;
      rvalid_nxt = rvalid_r;
      if (ce)
      begin
         rvalid_nxt = 1'b0;
         if (reg_rd)
         begin
            rvalid_nxt = 1'b1;
            if (reg_addr == `ISW_OFF_CFG)
            begin
               rdata_nxt = cfg_r;
            end
            else if (cfg_r[`ISW_CFG_PAGE])
            begin
               if (reg_addr[ADDR_W-1:3] == `ISW_OFF_SCR3 >> 3 &&
                   !reg_addr[0])
               begin
                  rdata_nxt = scr_r[3 - reg_addr[2:1]];
               end
               else
               begin
                  rdata_nxt = 8'h00;
               end
            end
            else if (reg_addr == `ISW_OFF_PROTECT)
            begin
               rdata_nxt = {wp_eff, ps_low_r};
            end
            else if (reg_addr == `ISW_OFF_TRIM)
            begin
               rdata_nxt = trim_r;
            end
            else
            begin
               rdata_nxt = 8'h00;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // ==========================================================
   // Protection flags
   // Events win over a flag write in the same cycle
   always_comb
   begin
      wp_sticky_nxt = wp_sticky_r;
      wp_otp_nxt = wp_otp_r;
      if (ce)
      begin
         if (power_rst)
         begin
            wp_otp_nxt = otp_wp;
         end
         // Brownout takes neither branch, so the flags stay locked
         if (warm_rst)
         begin
            wp_sticky_nxt = 4'h0;
         end
         else if (!any_rst && reg_wr && !cfg_r[`ISW_CFG_PAGE] &&
                  reg_addr == `ISW_OFF_PROTECT)
         begin
            // Software writes can only set sticky flags, never clear them
            wp_sticky_nxt = wp_sticky_r |
               reg_wdata[`ISW_WP_LSB +: 4];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_sticky_r <= 4'h0;
         wp_otp_r <= 4'hF;
      end
      else
      begin
         wp_sticky_r <= wp_sticky_nxt;
         wp_otp_r <= wp_otp_nxt;
      end
   end

   // ==========================================================
   // Registers
   // Asynchronous reset only loads constants; OTP values are taken on
   // the first enabled edge after release, through init_r.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_r <= `ISW_CFG_RESET;
         for (int i = 0; i < 4; i++)
         begin
            scr_r[i] <= 8'h00;
         end
         ps_low_r <= 4'h0;
         trim_r <= 8'h00;
         armed_r <= 1'b0;
         init_r <= 1'b1;
         int_clr_r <= 1'b0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         for (int i = 0; i < 4; i++)
         begin
            scr_r[i] <= scr_nxt[i];
         end
         ps_low_r <= ps_low_nxt;
         trim_r <= trim_nxt;
         armed_r <= armed_nxt;
         init_r <= init_nxt;
         int_clr_r <= int_clr_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign page_sel = cfg_r[`ISW_CFG_PAGE];
   assign force_osc_on = cfg_r[`ISW_CFG_FORCE_OSC];
   assign clock_output_src_32k = cfg_r[`ISW_CFG_CLK_SRC];
   assign clock_output_en = cfg_r[`ISW_CFG_CLK_EN];
   assign wdog_clk_from_clock_output = cfg_r[`ISW_CFG_WDOG_SEL];
   assign int_enable = cfg_r[`ISW_CFG_INT_EN];
   assign int_flag_clr = int_clr_r;
   assign wp_flags = wp_eff;
   assign grp_write_ok = ~wp_eff;
   assign rewrite_armed = armed_r;
   assign scratch_id = {scr_r[3], scr_r[2], scr_r[1], scr_r[0]};
   assign postscale_low = ps_low_r;
   assign load_trim = trim_r;

endmodule

//--- isw_aux_regs_properties.sv
// Concurrent checks on the auxiliary register bank ports.
// Bound into isw_aux_regs; one clock, async active-low reset.
`timescale 1ns/1ps
`include "isw_params.svh"
module isw_aux_regs_properties #(
   parameter int ADDR_W = 5
) (
   // Clock, reset and events
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic por_evt,
   input wire logic wdog_evt,
   input wire logic bo_evt,
   // OTP and register port
   input wire logic [3:0] otp_wp,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   // Bank outputs
   input wire logic page_sel,
   input wire logic clock_output_src_32k,
   input wire logic wdog_clk_from_clock_output,
   input wire logic int_flag_clr,
   input wire logic [3:0] wp_flags,
   input wire logic rewrite_armed,
   input wire logic [31:0] scratch_id,
   input wire logic [7:0] load_trim
);
   // ====================
   // Helpers
   // First edge after reset loads OTP and takes no write
   logic live_r;
   logic wgo;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         live_r <= 1'b0;
      else if (ce)
         live_r <= 1'b1;
   end
   assign wgo = live_r & ce & reg_wr & ~(por_evt | wdog_evt | bo_evt);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence cfg_s; wgo && reg_addr == `ISW_OFF_CFG; endsequence
   sequence trim_s; wgo && reg_addr == `ISW_OFF_TRIM && !page_sel; endsequence
   // ====================
   // Properties
   cfg_fields_a: assert property (
      cfg_s |=> page_sel == $past(reg_wdata[6]) &&
      clock_output_src_32k == $past(reg_wdata[4]) &&
      wdog_clk_from_clock_output == $past(reg_wdata[2]))
      else $error("config fields not taken");
   int_clear_a: assert property (
      cfg_s ##0 reg_wdata[1] |=> int_flag_clr) else $error("no clear pulse");
   id_write_a: assert property (
      wgo && page_sel && !wp_flags[3] && reg_addr == `ISW_OFF_SCR3
      |=> scratch_id[31:24] == $past(reg_wdata)) else $error("id write lost");
   id_lock_a: assert property (
      wgo && page_sel && wp_flags[3] |=> $stable(scratch_id))
      else $error("locked id changed");
   flag_sticky_a: assert property (
      live_r && ce && !por_evt && !wdog_evt
      |=> (wp_flags & $past(wp_flags)) == $past(wp_flags))
      else $error("protect flag dropped");
   flag_clear_a: assert property (
      ce && (por_evt || wdog_evt) |=> wp_flags == otp_wp)
      else $error("protect flags not reset");
   trim_once_a: assert property (
      cfg_s ##0 !reg_wdata[7] ##1 trim_s
      |=> load_trim[7:4] == $past(reg_wdata[7:4])) else $error("trim lost");
   trim_lock_a: assert property (
      trim_s ##0 !rewrite_armed |=> $stable(load_trim[7:4]))
      else $error("trim changed while locked");
endmodule

bind isw_aux_regs isw_aux_regs_properties #(.ADDR_W(ADDR_W))
   i_isw_aux_regs_properties (.core_clk, .rst_n, .ce, .por_evt, .wdog_evt,
   .bo_evt, .otp_wp, .reg_addr, .reg_wr, .reg_wdata, .page_sel,
   .clock_output_src_32k, .wdog_clk_from_clock_output, .int_flag_clr, .wp_flags,
   .rewrite_armed, .scratch_id, .load_trim);

//--- isw_host_model.sv
// Host side of the bank's register port, driven through tasks.
// Shares the bank clock; every task except idle starts by waiting for an edge.
`timescale 1ns/1ps
`include "isw_params.svh"
module isw_host_model (
   // Clock
   input wire logic core_clk,
   // Register port
   output logic [4:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   initial
   begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h0000;
   end
   // Released lines flip, so a stale copy never passes for data
   task automatic idle;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
      #1;
   endtask
   task automatic put(input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      put(a, d);
      @(posedge core_clk);
      idle;
   endtask
   task automatic rd(input logic [4:0] a, output logic [8:0] v);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      idle;
      v = {reg_rvalid, reg_rdata};
   endtask
   // Strobe stays up so nothing slips between unlock and trim write
   task automatic trim(input logic [7:0] d);
      put(`ISW_OFF_CFG, 8'h08);
      put(`ISW_OFF_TRIM, d);
      @(posedge core_clk);
      idle;
   endtask
endmodule

//--- id_scratchpad_write_protect_tb.sv
// Self-checking bench: the host model drives the register port.
// Assumes the bank, its checker and the host model are compiled first.
`timescale 1ns/1ps
module id_scratchpad_write_protect_tb;
   typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} isw_row_s;
   localparam logic [31:0] OID = 32'h1234_5678;
   logic core_clk, rst_n, ce, por_evt, wdog_evt, bo_evt, reg_wr, reg_rd;
   logic reg_rvalid, page_sel, force_osc_on, clock_output_src_32k, clock_output_en;
   logic wdog_clk_from_clock_output, int_enable, int_flag_clr, rewrite_armed;
   logic [3:0] wp_flags, grp_write_ok, postscale_low;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, load_trim;
   logic [31:0] scratch_id;
   logic [8:0] v;
   logic [5:0] cfg_o;
   int failures, checks;
   isw_row_s rows [9] = '{'{5'h0E, 8'h40, 8'h40}, '{5'h10, 8'hA1, 8'hA1},
      '{5'h12, 8'hB2, 8'hB2}, '{5'h14, 8'hC3, 8'hC3}, '{5'h16, 8'hD4, 8'hD4},
      '{5'h11, 8'h5A, 8'h00}, '{5'h0E, 8'h57, 8'h55},
      '{5'h0E, 8'h17, 8'h15}, '{5'h10, 8'h77, 8'h00}};
   assign cfg_o = {page_sel, force_osc_on, clock_output_src_32k, clock_output_en,
      wdog_clk_from_clock_output, int_enable};
   isw_aux_regs i_isw_aux_regs (.core_clk, .rst_n, .ce, .por_evt, .wdog_evt,
      .bo_evt, .otp_id(OID), .otp_wp(4'h4), .otp_ps_low(4'h5),
      .otp_trim(8'h3C), .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .reg_rvalid, .page_sel, .force_osc_on, .clock_output_src_32k,
      .clock_output_en, .wdog_clk_from_clock_output, .int_enable, .int_flag_clr,
      .wp_flags, .grp_write_ok, .rewrite_armed, .scratch_id,
      .postscale_low, .load_trim);
   isw_host_model i_isw_host_model (.core_clk, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .reg_rvalid);
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // The whole run needs under a hundred cycles; 5000 means a hang
   initial
   begin
      #20000;
      failures++;
      stop_test;
   end
   task automatic check(input string n, input logic [31:0] s, e);
      checks++;
      if (s !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test;
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic evt(input logic [2:0] k);
      @(posedge core_clk);
      {por_evt, wdog_evt, bo_evt} <= k;
      @(posedge core_clk);
      {por_evt, wdog_evt, bo_evt} <= 3'h0;
      #1;
   endtask
   initial
   begin
      {rst_n, ce, por_evt, wdog_evt, bo_evt} = 5'h08;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      check("scratch_id", scratch_id, OID);
      check("wp_flags", wp_flags, 4'h4);
      check("grp_write_ok", grp_write_ok, 4'hB);
      i_isw_host_model.rd(5'h0E, v);
      check("config", v, 9'h188);
      foreach (rows[i])
      begin
         i_isw_host_model.wr(rows[i].a, rows[i].d);
         i_isw_host_model.rd(rows[i].a, v);
         check("row", v, {1'b1, rows[i].e});
      end
      check("scratch_id", scratch_id, 32'hA1B2_C3D4);
      check("config outputs", cfg_o, 6'h0B);
      i_isw_host_model.trim(8'h9F);
      check("load_trim", load_trim, 8'h9C);
      i_isw_host_model.wr(5'h12, 8'h5F);
      check("load_trim", load_trim, 8'h9C);
      i_isw_host_model.wr(5'h17, 8'h83);
      check("wp_flags", wp_flags, 4'hC);
      check("postscale_low", postscale_low, 4'h3);
      i_isw_host_model.wr(5'h17, 8'h00);
      check("wp_flags", wp_flags, 4'hC);
      i_isw_host_model.wr(5'h0E, 8'h42);
      check("int_flag_clr", int_flag_clr, 1'b1);
      check("rewrite_armed", rewrite_armed, 1'b1);
      i_isw_host_model.wr(5'h10, 8'hEE);
      check("scratch_id", scratch_id, 32'hA1B2_C3D4);
      evt(3'h1);
      check("wp_flags", wp_flags, 4'hC);
      check("scratch_id", scratch_id, OID);
      evt(3'h2);
      check("wp_flags", wp_flags, 4'h4);
      i_isw_host_model.wr(5'h17, 8'h80);
      evt(3'h4);
      check("wp_flags", wp_flags, 4'h4);
      i_isw_host_model.rd(5'h0E, v);
      check("config", v, 9'h188);
      // A write while the enable is low must leave every register alone
      @(posedge core_clk);
      ce <= 1'b0;
      i_isw_host_model.wr(5'h0E, 8'h40);
      check("page_sel", page_sel, 1'b0);
      @(posedge core_clk);
      ce <= 1'b1;
      stop_test;
   end
endmodule
